// File: iads_cfg.svh
`ifndef IADS_CFG_SVH
`define IADS_CFG_SVH

// opcode byte views: hi[7:6] sel[5:3] form[2] dir[1] wide[0]
`define IADS_HI_ALU 2'b00
`define IADS_OP_IMM_GRP 6'b100000
`define IADS_OP_INC_GRP 7'b1111111
`define IADS_OP_INC_SHORT 5'b01000
`define IADS_OP_SET_DIR 8'hfd
`define IADS_OP_SET_IE 8'hfb

// operation select values, shared by opcode bits and the addressing byte
`define IADS_SEL_ADD 3'b000
`define IADS_SEL_ADC 3'b010
`define IADS_SEL_SBB 3'b011
`define IADS_SEL_SUB 3'b101
`define IADS_SEL_INC 3'b000

// addressing byte decode
`define IADS_MOD_REG 2'b11
`define IADS_MOD_NODISP 2'b00
`define IADS_MOD_DISP8 2'b01
`define IADS_MOD_DISP32 2'b10
`define IADS_RM_SIB 3'b100
`define IADS_RM_DISP32 3'b101

// trailing byte counts
`define IADS_LEN_NONE 3'd0
`define IADS_LEN_BYTE 3'd1
`define IADS_LEN_WORD 3'd4
`define IADS_LEFT_LAST 3'd1

// execution clock counts, identical in every operating mode
`define IADS_CLK_REG 4'd2
`define IADS_CLK_MEM_DST 4'd7
`define IADS_CLK_MEM_SRC 4'd6
`define IADS_CLK_INC_MEM 4'd6
`define IADS_CLK_SET_DIR 4'd2
`define IADS_CLK_SET_IE 4'd8
`define IADS_CNT_LAST 4'd1

// byte operands are lifted to the top lane so flags come from bit 31/32
`define IADS_BYTE_SHIFT 6'd24
`define IADS_WORD_SHIFT 6'd0

// reset values
`define IADS_READY_RST 1'b1
`define IADS_DIR_FLAG_RST 1'b0
`define IADS_IE_FLAG_RST 1'b0

`endif

// File: iads_pkg.sv
`default_nettype none
package iads_pkg;

	typedef enum logic [3:0] {
		IADS_K_NONE,
		IADS_K_ADD,
		IADS_K_ADC,
		IADS_K_SUB,
		IADS_K_SBB,
		IADS_K_INC,
		IADS_K_SET_DIR,
		IADS_K_SET_IE
	} iads_kind_e;

	typedef enum logic [2:0] {
		IADS_S_OPC,
		IADS_S_MODRM,
		IADS_S_SIB,
		IADS_S_DISP,
		IADS_S_IMM,
		IADS_S_EXEC
	} iads_state_e;

	typedef struct packed {
		logic [1:0] hi;
		logic [2:0] sel;
		logic form;
		logic dir;
		logic wide;
	} iads_grp_s;

	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] sel;
		logic [2:0] rm;
	} iads_modrm_s;

	typedef struct packed {
		logic [1:0] scale;
		logic [2:0] index;
		logic [2:0] base;
	} iads_sib_s;

	typedef struct packed {
		iads_kind_e kind;
		logic wide;
		logic dir;
		logic sext;
		logic use_imm;
		logic acc;
		logic mem;
		logic [2:0] reg_sel;
		logic [2:0] rm;
		logic [31:0] imm;
		logic [3:0] clocks;
	} iads_dec_s;

	typedef struct packed {
		logic cf;
		logic zf;
		logic sf;
		logic of;
	} iads_flags_s;

	typedef struct packed {
		iads_state_e st;
		iads_dec_s dec;
		logic [1:0] mode;
		logic [3:0] cnt;
		logic [2:0] left;
		logic ready;
		logic done;
		logic illegal;
		logic [31:0] result;
		iads_flags_s flags;
		logic dir_flag;
		logic ie_flag;
	} iads_state_s;

endpackage
`default_nettype wire

// File: iads_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "iads_cfg.svh"

// Behaviour
// - register-to-register add completes in 2 clocks
// - add from register into memory takes 7 clocks
// - add from memory into register takes 6 clocks
// - immediate group select 000 is add: 2 clocks register, 7 memory
// - accumulator short add with immediate takes 2 clocks
// - register-to-register add with carry completes in 2 clocks
// - add with carry into memory takes 7 clocks
// - add with carry from memory into register takes 6 clocks
// - immediate group select 010 is add with carry: 2 or 7 clocks
// - accumulator short add with carry takes 2 clocks
// - plus-one group select 000 takes 2 clocks register, 6 memory
// - register-to-register subtract completes in 2 clocks
// - subtract updating memory from register takes 7 clocks
// - subtract from memory into register takes 6 clocks
// - immediate group select 101 is subtract: 2 or 7 clocks
// - accumulator short subtract takes 2 clocks
// - register-to-register subtract with borrow completes in 2 clocks
// - subtract with borrow updating memory takes 7 clocks
// - subtract with borrow from memory into register takes 6 clocks
// - immediate group select 011 is subtract with borrow: 2 or 7 clocks
// - set direction flag operation completes in 2 clocks
// - set interrupt enable operation completes in 8 clocks
module iads_decoder (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	input wire logic [31:0] i_dst_val,
	input wire logic [31:0] i_src_val,
	input wire logic i_carry_flag,
	output logic o_ready,
	output logic o_done,
	output logic o_illegal,
	output var iads_pkg::iads_dec_s o_dec,
	output logic [31:0] o_result,
	output var iads_pkg::iads_flags_s o_flags,
	output logic o_dir_flag,
	output logic o_int_en
);

	iads_pkg::iads_state_s s_r;
	iads_pkg::iads_state_s s_nxt;
	iads_pkg::iads_grp_s op;
	iads_pkg::iads_modrm_s mr;
	iads_pkg::iads_sib_s sb;
	logic take;
	logic sub_op;
	logic cin;
	logic [5:0] sh;
	logic [31:0] opa;
	logic [31:0] opb;
	logic [31:0] b_raw;
	logic [32:0] cin_v;
	logic [32:0] res;
	logic [31:0] alu_res;
	iads_pkg::iads_flags_s alu_flags;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	function automatic iads_pkg::iads_kind_e kind_of(input logic [2:0] sel);
		case (sel)
			`IADS_SEL_ADD: kind_of = iads_pkg::IADS_K_ADD;
			`IADS_SEL_ADC: kind_of = iads_pkg::IADS_K_ADC;
			`IADS_SEL_SBB: kind_of = iads_pkg::IADS_K_SBB;
			`IADS_SEL_SUB: kind_of = iads_pkg::IADS_K_SUB;
			default: kind_of = iads_pkg::IADS_K_NONE;
		endcase
	endfunction

	// displacement bytes only keep the stream aligned; the address is formed elsewhere
	function automatic logic [2:0] disp_len(input logic [1:0] mode, input logic [2:0] base);
		if (mode == `IADS_MOD_DISP8) begin
			disp_len = `IADS_LEN_BYTE;
		end else if (mode == `IADS_MOD_DISP32) begin
			disp_len = `IADS_LEN_WORD;
		end else if (mode == `IADS_MOD_NODISP && base == `IADS_RM_DISP32) begin
			disp_len = `IADS_LEN_WORD;
		end else begin
			disp_len = `IADS_LEN_NONE;
		end
	endfunction

	function automatic logic [2:0] imm_len(input logic wide, input logic sext);
		imm_len = (wide && !sext) ? `IADS_LEN_WORD : `IADS_LEN_BYTE;
	endfunction

	function automatic iads_pkg::iads_state_s after_addr(input iads_pkg::iads_state_s s, input logic [2:0] disp);
		iads_pkg::iads_state_s t;
		t = s;
		if (disp != `IADS_LEN_NONE) begin
			t.left = disp;
			t.st = iads_pkg::IADS_S_DISP;
		end else if (s.dec.use_imm) begin
			t.left = imm_len(s.dec.wide, s.dec.sext);
			t.st = iads_pkg::IADS_S_IMM;
		end else begin
			t.cnt = s.dec.clocks;
			t.st = iads_pkg::IADS_S_EXEC;
		end
		return t;
	endfunction

	assign op = iads_pkg::iads_grp_s'(i_byte);
	assign mr = iads_pkg::iads_modrm_s'(i_byte);
	assign sb = iads_pkg::iads_sib_s'(i_byte);
	assign take = i_byte_valid && s_r.ready;

	// byte operands move to the top lane, so one 32-bit adder yields every flag except the carry that plus-one keeps
	assign sh = s_r.dec.wide ? `IADS_WORD_SHIFT : `IADS_BYTE_SHIFT;
	assign sub_op = s_r.dec.kind == iads_pkg::IADS_K_SUB || s_r.dec.kind == iads_pkg::IADS_K_SBB;
	assign cin = (s_r.dec.kind == iads_pkg::IADS_K_ADC || s_r.dec.kind == iads_pkg::IADS_K_SBB) && i_carry_flag;
	assign b_raw = s_r.dec.use_imm ? s_r.dec.imm : (s_r.dec.kind == iads_pkg::IADS_K_INC ? 32'h1 : i_src_val);
	assign opa = i_dst_val << sh;
	assign opb = b_raw << sh;
	assign cin_v = {32'h0, cin} << sh;
	assign res = sub_op ? ({1'b0, opa} - {1'b0, opb} - cin_v) : ({1'b0, opa} + {1'b0, opb} + cin_v);
	assign alu_res = res[31:0] >> sh;
	assign alu_flags.cf = (s_r.dec.kind == iads_pkg::IADS_K_INC) ? i_carry_flag : res[32];
	assign alu_flags.zf = res[31:0] == 32'h0;
	assign alu_flags.sf = res[31];
	assign alu_flags.of = sub_op ? ((opa[31] ^ opb[31]) & (opa[31] ^ res[31]))
		: (~(opa[31] ^ opb[31]) & (opa[31] ^ res[31]));

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.illegal = 1'b0;
		case (s_r.st)
			iads_pkg::IADS_S_OPC: begin
				if (take) begin
					s_nxt.dec = '0;
					s_nxt.dec.wide = op.wide;
					s_nxt.dec.dir = op.dir;
					if (op.hi == `IADS_HI_ALU && !op.form && kind_of(op.sel) != iads_pkg::IADS_K_NONE) begin
						s_nxt.dec.kind = kind_of(op.sel);
						s_nxt.st = iads_pkg::IADS_S_MODRM;
					end else if (op.hi == `IADS_HI_ALU && op.form && !op.dir
						&& kind_of(op.sel) != iads_pkg::IADS_K_NONE) begin
						s_nxt.dec.kind = kind_of(op.sel);
						s_nxt.dec.dir = 1'b1;
						s_nxt.dec.use_imm = 1'b1;
						s_nxt.dec.acc = 1'b1;
						s_nxt.dec.clocks = `IADS_CLK_REG;
						s_nxt.left = imm_len(op.wide, 1'b0);
						s_nxt.st = iads_pkg::IADS_S_IMM;
					end else if ({op.hi, op.sel, op.form} == `IADS_OP_IMM_GRP) begin
						s_nxt.dec.use_imm = 1'b1;
						s_nxt.dec.sext = op.dir;
						s_nxt.dec.dir = 1'b0;
						s_nxt.st = iads_pkg::IADS_S_MODRM;
					end else if ({op.hi, op.sel, op.form, op.dir} == `IADS_OP_INC_GRP) begin
						s_nxt.dec.kind = iads_pkg::IADS_K_INC;
						s_nxt.dec.dir = 1'b0;
						s_nxt.st = iads_pkg::IADS_S_MODRM;
					end else if ({mr.mode, mr.sel} == `IADS_OP_INC_SHORT) begin
						s_nxt.dec.kind = iads_pkg::IADS_K_INC;
						s_nxt.dec.wide = 1'b1;
						s_nxt.dec.rm = mr.rm;
						s_nxt.dec.clocks = `IADS_CLK_REG;
						s_nxt.cnt = `IADS_CLK_REG;
						s_nxt.st = iads_pkg::IADS_S_EXEC;
					end else if (i_byte == `IADS_OP_SET_DIR) begin
						s_nxt.dec.kind = iads_pkg::IADS_K_SET_DIR;
						s_nxt.dec.clocks = `IADS_CLK_SET_DIR;
						s_nxt.cnt = `IADS_CLK_SET_DIR;
						s_nxt.st = iads_pkg::IADS_S_EXEC;
					end else if (i_byte == `IADS_OP_SET_IE) begin
						s_nxt.dec.kind = iads_pkg::IADS_K_SET_IE;
						s_nxt.dec.clocks = `IADS_CLK_SET_IE;
						s_nxt.cnt = `IADS_CLK_SET_IE;
						s_nxt.st = iads_pkg::IADS_S_EXEC;
					end else begin
						s_nxt.illegal = 1'b1;
					end
				end
			end
			iads_pkg::IADS_S_MODRM: begin
				if (take) begin
					s_nxt.mode = mr.mode;
					s_nxt.dec.reg_sel = mr.sel;
					s_nxt.dec.rm = mr.rm;
					s_nxt.dec.mem = mr.mode != `IADS_MOD_REG;
					if (s_r.dec.use_imm) begin
						s_nxt.dec.kind = kind_of(mr.sel);
					end
					if (!s_nxt.dec.mem) begin
						s_nxt.dec.clocks = `IADS_CLK_REG;
					end else if (s_r.dec.kind == iads_pkg::IADS_K_INC) begin
						s_nxt.dec.clocks = `IADS_CLK_INC_MEM;
					end else if (s_r.dec.use_imm || !s_r.dec.dir) begin
						s_nxt.dec.clocks = `IADS_CLK_MEM_DST;
					end else begin
						s_nxt.dec.clocks = `IADS_CLK_MEM_SRC;
					end
					// the stream is not resynchronised after a bad select; the feeder must flush
					if ((s_r.dec.use_imm && kind_of(mr.sel) == iads_pkg::IADS_K_NONE)
						|| (s_r.dec.kind == iads_pkg::IADS_K_INC && mr.sel != `IADS_SEL_INC)) begin
						s_nxt.illegal = 1'b1;
						s_nxt.dec.kind = iads_pkg::IADS_K_NONE;
						s_nxt.st = iads_pkg::IADS_S_OPC;
					end else if (s_nxt.dec.mem && mr.rm == `IADS_RM_SIB) begin
						s_nxt.st = iads_pkg::IADS_S_SIB;
					end else begin
						s_nxt = after_addr(s_nxt, disp_len(mr.mode, mr.rm));
					end
				end
			end
			iads_pkg::IADS_S_SIB: begin
				if (take) begin
					s_nxt = after_addr(s_nxt, disp_len(s_r.mode, sb.base));
				end
			end
			iads_pkg::IADS_S_DISP: begin
				if (take) begin
					s_nxt.left = s_r.left - `IADS_LEFT_LAST;
					if (s_r.left == `IADS_LEFT_LAST) begin
						s_nxt = after_addr(s_nxt, `IADS_LEN_NONE);
					end
				end
			end
			iads_pkg::IADS_S_IMM: begin
				if (take) begin
					s_nxt.left = s_r.left - `IADS_LEFT_LAST;
					s_nxt.dec.imm = {i_byte, s_r.dec.imm[31:8]};
					if (s_r.left == `IADS_LEFT_LAST) begin
						if (imm_len(s_r.dec.wide, s_r.dec.sext) == `IADS_LEN_BYTE) begin
							s_nxt.dec.imm = (s_r.dec.wide && s_r.dec.sext) ? {{24{i_byte[7]}}, i_byte}
								: {24'h0, i_byte};
						end
						s_nxt.cnt = s_r.dec.clocks;
						s_nxt.st = iads_pkg::IADS_S_EXEC;
					end
				end
			end
			iads_pkg::IADS_S_EXEC: begin
				s_nxt.cnt = s_r.cnt - `IADS_CNT_LAST;
				if (s_r.cnt == `IADS_CNT_LAST) begin
					s_nxt.done = 1'b1;
					s_nxt.st = iads_pkg::IADS_S_OPC;
					case (s_r.dec.kind)
						iads_pkg::IADS_K_SET_DIR: s_nxt.dir_flag = 1'b1;
						iads_pkg::IADS_K_SET_IE: s_nxt.ie_flag = 1'b1;
						default: begin
							s_nxt.result = alu_res;
							s_nxt.flags = alu_flags;
						end
					endcase
				end
			end
			default: s_nxt.st = iads_pkg::IADS_S_OPC;
		endcase
		s_nxt.ready = s_nxt.st != iads_pkg::IADS_S_EXEC;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '0;
			s_r.ready <= `IADS_READY_RST;
			s_r.dir_flag <= `IADS_DIR_FLAG_RST;
			s_r.ie_flag <= `IADS_IE_FLAG_RST;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_ready = s_r.ready;
	assign o_done = s_r.done;
	assign o_illegal = s_r.illegal;
	assign o_dec = s_r.dec;
	assign o_result = s_r.result;
	assign o_flags = s_r.flags;
	assign o_dir_flag = s_r.dir_flag;
	assign o_int_en = s_r.ie_flag;

	// cycles spent executing, for the timing checks only
	logic [3:0] xlen_q;
	logic was_exec_q;
	logic arith_done;
	// gated like the state, so a done held by a low enable still counts as the end of execution
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			xlen_q <= 4'h0;
			was_exec_q <= 1'b0;
		end else if (i_ce) begin
			was_exec_q <= s_r.st == iads_pkg::IADS_S_EXEC;
			if (s_r.st == iads_pkg::IADS_S_EXEC) begin
				xlen_q <= xlen_q + 4'h1;
			end else begin
				xlen_q <= 4'h0;
			end
		end
	end
	assign arith_done = s_r.done && was_exec_q
		&& s_r.dec.kind inside {iads_pkg::IADS_K_ADD, iads_pkg::IADS_K_ADC, iads_pkg::IADS_K_SUB, iads_pkg::IADS_K_SBB};

	a_rr_two_clk: assert property (arith_done && !s_r.dec.mem && !s_r.dec.acc |-> xlen_q == `IADS_CLK_REG)
		else $error("register form did not take two clocks");
	a_mem_dst_clk: assert property (arith_done && s_r.dec.mem && (s_r.dec.use_imm || !s_r.dec.dir)
		|-> xlen_q == `IADS_CLK_MEM_DST)
		else $error("memory destination timing wrong");
	a_mem_src_clk: assert property (arith_done && s_r.dec.mem && s_r.dec.dir && !s_r.dec.use_imm
		|-> xlen_q == `IADS_CLK_MEM_SRC)
		else $error("memory source timing wrong");
	a_acc_short_clk: assert property (arith_done && s_r.dec.acc |-> xlen_q == `IADS_CLK_REG && !s_r.dec.mem)
		else $error("accumulator short form timing wrong");
	a_inc_clk: assert property (s_r.done && s_r.dec.kind == iads_pkg::IADS_K_INC
		|-> xlen_q == (s_r.dec.mem ? `IADS_CLK_INC_MEM : `IADS_CLK_REG))
		else $error("plus-one timing wrong");
	a_set_dir_op: assert property (s_r.st == iads_pkg::IADS_S_EXEC && s_r.dec.kind == iads_pkg::IADS_K_SET_DIR
		&& s_r.cnt == `IADS_CLK_SET_DIR && i_ce ##1 i_ce |=> o_done && o_dir_flag && xlen_q == `IADS_CLK_SET_DIR)
		else $error("direction flag set late or not at all");
	a_set_ie_op: assert property (s_r.done && s_r.dec.kind == iads_pkg::IADS_K_SET_IE
		|-> xlen_q == `IADS_CLK_SET_IE && o_int_en)
		else $error("interrupt enable timing wrong");
	a_byte_narrow: assert property (arith_done && !s_r.dec.wide |-> o_result[31:8] == 24'h0)
		else $error("byte result spills above low lane");
	a_sext_imm: assert property (s_r.st == iads_pkg::IADS_S_EXEC && s_r.dec.use_imm && s_r.dec.sext && s_r.dec.wide
		|-> s_r.dec.imm[31:8] == {24{s_r.dec.imm[7]}})
		else $error("immediate byte not sign extended");
	a_inc_keeps_cf: assert property (s_r.done && $past(s_r.st) == iads_pkg::IADS_S_EXEC
		&& s_r.dec.kind == iads_pkg::IADS_K_INC |-> o_flags.cf == $past(i_carry_flag))
		else $error("plus-one changed carry");
	a_inc_adds_one: assert property (s_r.done && $past(s_r.st) == iads_pkg::IADS_S_EXEC
		&& s_r.dec.kind == iads_pkg::IADS_K_INC && s_r.dec.wide |-> o_result == $past(i_dst_val) + 32'h1)
		else $error("plus-one result wrong");
	a_adc_uses_cf: assert property (arith_done && s_r.dec.kind == iads_pkg::IADS_K_ADC && s_r.dec.wide
		&& !s_r.dec.use_imm |-> o_result == $past(i_dst_val + i_src_val + {31'h0, i_carry_flag}))
		else $error("add with carry result wrong");
	a_sbb_uses_cf: assert property (arith_done && s_r.dec.kind == iads_pkg::IADS_K_SBB && s_r.dec.wide
		&& !s_r.dec.use_imm |-> o_result == $past(i_dst_val - i_src_val - {31'h0, i_carry_flag}))
		else $error("subtract with borrow result wrong");
	a_busy_no_take: assert property (s_r.st == iads_pkg::IADS_S_EXEC |-> !o_ready)
		else $error("byte accepted during execution");

endmodule
`default_nettype wire

// File: iads_feeder.sv
`timescale 1ns/1ps
`default_nettype none
// prefetch queue model: offers the oldest byte and holds it until the decoder takes it
module iads_feeder (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_ready,
	input wire logic i_slow,
	output logic o_byte_valid,
	output logic [7:0] o_byte
);
	logic [7:0] q[$];
	logic took;
	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask
	initial begin
		o_byte_valid = 1'b0;
		o_byte = 8'h00;
		forever begin
			@(posedge i_clk);
			took = o_byte_valid && i_ready && i_ce && i_resetn;
			#1;
			if (took)
				void'(q.pop_front());
			if (!i_resetn)
				q.delete();
			// slow mode leaves one idle cycle after each taken byte, never drops an offer
			if (q.size() > 0 && !(i_slow && took)) begin
				o_byte_valid = 1'b1;
				o_byte = q[0];
			end else begin
				// nothing on offer: invert so a stale byte never looks like data
				o_byte_valid = 1'b0;
				o_byte = ~o_byte;
			end
		end
	end
endmodule
`default_nettype wire

// File: iads_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
module iads_decoder_bench;
	localparam int NT = 30;
	// kind, clocks, byte count, then up to six bytes with the first byte leftmost
	localparam logic [59:0] TBL [NT] = '{
		60'h122_0000000001c8, 60'h172_000000000100, 60'h173_000000010424,
		60'h162_000000000300, 60'h126_81c001000000, 60'h173_00000083007f,
		60'h125_000501000000, 60'h122_000000000401, 60'h222_0000000011c8,
		60'h273_000000114010, 60'h266_138000000000, 60'h226_81d001000000,
		60'h273_000000801001, 60'h225_001501000000, 60'h522_00000000ffc0,
		60'h562_00000000ff00, 60'h521_000000000040, 60'h322_0000000029c8,
		60'h372_000000002900, 60'h362_000000002b00, 60'h326_81e801000000,
		60'h373_000000832801, 60'h325_002d01000000, 60'h422_0000000019c8,
		60'h472_000000001900, 60'h462_000000001b00, 60'h423_00000083d801,
		60'h476_811801000000, 60'h621_0000000000fd, 60'h781_0000000000fb
	};
	logic clk, resetn, ce, slow, carry, valid, ready, done, illegal, dir_flag, int_en;
	logic [7:0] bt;
	logic [31:0] dst, src, result;
	iads_pkg::iads_dec_s dec;
	iads_pkg::iads_flags_s flags;
	int miscompares, n_tests;

	iads_decoder u_iads_decoder (
		.i_clk(clk),
		.i_resetn(resetn),
		.i_ce(ce),
		.i_byte_valid(valid),
		.i_byte(bt),
		.i_dst_val(dst),
		.i_src_val(src),
		.i_carry_flag(carry),
		.o_ready(ready),
		.o_done(done),
		.o_illegal(illegal),
		.o_dec(dec),
		.o_result(result),
		.o_flags(flags),
		.o_dir_flag(dir_flag),
		.o_int_en(int_en)
	);
	iads_feeder u_iads_feeder (
		.i_clk(clk),
		.i_resetn(resetn),
		.i_ce(ce),
		.i_ready(ready),
		.i_slow(slow),
		.o_byte_valid(valid),
		.o_byte(bt)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic send(input logic [47:0] b, input int nb);
		for (int i = nb - 1; i >= 0; i--)
			u_iads_feeder.push(b[8 * i +: 8]);
	endtask
	// counts cycles with ready low up to o_done; stall holds the enable low for that many cycles mid-run
	task automatic finish_one(input int stall, output int cnt);
		cnt = 0;
		for (int t = 0; t < 200; t++) begin
			@(posedge clk);
			#1;
			if (ready === 1'b0)
				cnt++;
			if (done === 1'b1)
				return;
			ce = !(cnt >= 2 && cnt < 2 + stall);
		end
		check("timeout", 32'h1, 32'h0);
		end_of_test();
	endtask
	function automatic logic [32:0] b9(input logic [8:0] r);
		return {r[8], 24'h0, r[7:0]};
	endfunction

	task automatic sc_b2b();
		int cnt;
		send(48'h01c8fdfb, 4);
		finish_one(0, cnt);
		check("add cycles", 32'(cnt), 32'd2);
		finish_one(0, cnt);
		check("std cycles", 32'(cnt), 32'd2);
		check("dir flag", 32'(dir_flag), 32'h1);
		finish_one(3, cnt);
		check("sti stalled", 32'(cnt), 32'd11);
		check("int en", 32'(int_en), 32'h1);
	endtask
	task automatic sc_table();
		int cnt;
		for (int i = 0; i < NT; i++) begin
			send(TBL[i][47:0], int'(TBL[i][51:48]));
			finish_one(0, cnt);
			check("cycles", 32'(cnt), 32'(TBL[i][55:52]));
			check("dec clk", 32'(dec.clocks), 32'(TBL[i][55:52]));
			check("kind", 32'(dec.kind), 32'(TBL[i][59:56]));
		end
	endtask
	task automatic alu_case(input logic [47:0] b, input int nb, input logic [31:0] a, input logic [31:0] s,
			input logic c, input logic [32:0] exp);
		int cnt;
		logic w;
		// the width bit is bit 0 of the first byte in every form used here
		w = b[8 * (nb - 1)];
		dst = a;
		src = s;
		carry = c;
		send(b, nb);
		finish_one(0, cnt);
		check("result", result, exp[31:0]);
		check("cf", 32'(flags.cf), 32'(exp[32]));
		check("zf", 32'(flags.zf), 32'(exp[31:0] == 32'h0));
		check("sf", 32'(flags.sf), 32'(w ? exp[31] : exp[7]));
	endtask
	task automatic sc_alu();
		alu_case(48'h01c8, 2, 32'hffffffff, 32'h1, 1'b0, {1'b0, 32'hffffffff} + 33'h1);
		alu_case(48'h11c8, 2, 32'h1, 32'h2, 1'b1, 33'h1 + 33'h2 + 33'h1);
		alu_case(48'h18c8, 2, 32'h5, 32'h7, 1'b1, b9(9'h5 - 9'h7 - 9'h1));
		alu_case(48'h2bc8, 2, 32'h5, 32'h7, 1'b0, {1'b0, 32'h5} - {1'b0, 32'h7});
		alu_case(48'hffc0, 2, 32'hffffffff, 32'h0, 1'b1, {1'b1, 32'hffffffff + 32'h1});
		alu_case(48'h83c0ff, 3, 32'h1, 32'h0, 1'b0, 33'h1 + {1'b0, 32'hffffffff});
		check("imm", dec.imm, 32'hffffffff);
		alu_case(48'h2c01, 2, 32'h0, 32'h0, 1'b0, b9(9'h0 - 9'h1));
		alu_case(48'h80d0ff, 3, 32'h1, 32'h0, 1'b1, b9(9'h1 + 9'hff + 9'h1));
	endtask
	task automatic sc_illegal();
		logic [47:0] bad [3] = '{48'h0f, 48'h81c8, 48'hffc8};
		int nb [3] = '{1, 2, 2};
		logic seen;
		for (int i = 0; i < 3; i++) begin
			send(bad[i], nb[i]);
			seen = 1'b0;
			for (int t = 0; t < 8; t++) begin
				@(posedge clk);
				#1;
				seen |= (illegal === 1'b1);
			end
			check("illegal", 32'(seen), 32'h1);
		end
	endtask
	// reset in the middle of a long execution must abandon it and clear the flags
	task automatic sc_reset();
		send(48'hfb, 1);
		repeat (4) @(posedge clk);
		#1;
		resetn = 1'b0;
		@(posedge clk);
		#1;
		check("rst ready", 32'(ready), 32'h1);
		check("rst int en", 32'(int_en), 32'h0);
		check("rst dir", 32'(dir_flag), 32'h0);
		@(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (12) @(posedge clk);
		#1;
		check("no done", 32'(done), 32'h0);
		check("idle int en", 32'(int_en), 32'h0);
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		resetn = 1'b0;
		ce = 1'b1;
		slow = 1'b0;
		carry = 1'b0;
		dst = 32'h0;
		src = 32'h0;
		miscompares = 0;
		n_tests = 0;
		repeat (16) @(posedge clk);
		#1;
		check("reset ready", 32'(ready), 32'h1);
		check("reset kind", 32'(dec.kind), 32'h0);
		check("reset flags", {30'h0, dir_flag, int_en}, 32'h0);
		resetn = 1'b1;
		sc_b2b();
		sc_table();
		slow = 1'b1;
		sc_table();
		slow = 1'b0;
		sc_alu();
		sc_illegal();
		sc_reset();
		end_of_test();
	end
endmodule
`default_nettype wire
